// file: inc/cctl_pkg.sv
// constants for the charger timer and control register bank

package cctl_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RESET_ADDR   = 8'h09;
	localparam logic [7:0] TIMER_CTRL_ADDR  = 8'h0e;
	localparam logic [7:0] CHG_CTRL0_ADDR   = 8'h0f;

	// ------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------
	localparam logic [7:0] TIMER_CTRL_RESET = 8'h3d;
	localparam logic [7:0] CHG_CTRL0_RESET  = 8'ha2;
	localparam logic [7:0] CHG_CTRL0_WD_MASK = 8'h2a; // fields the watchdog restores
	localparam logic [7:0] CHG_CTRL0_RW_MASK = 8'hfe; // bit 0 reserved, reads zero

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_PRECHG_EN = 4;
	localparam int BIT_FAST_EN   = 3;
	localparam int BIT_DUR_MSB   = 2;
	localparam int BIT_DUR_LSB   = 1;
	localparam int BIT_SLOWDOWN  = 0;
	localparam int BIT_AUTO_DIS  = 7;
	localparam int BIT_FORCE_DIS = 6;
	localparam int BIT_CHG_EN    = 5;
	localparam int BIT_OPT_EN    = 4;
	localparam int BIT_OPT_START = 3;
	localparam int BIT_HIZ       = 2;
	localparam int BIT_TERM      = 1;
	localparam int BIT_REG_RESET = 6;

	// ------------------------------------------------------------
	// durations and timing
	// ------------------------------------------------------------
	localparam logic [1:0] DUR_CODE_5H  = 2'h0;
	localparam logic [1:0] DUR_CODE_8H  = 2'h1;
	localparam logic [1:0] DUR_CODE_12H = 2'h2;
	localparam logic [3:0] HOURS_5      = 4'h5;
	localparam logic [3:0] HOURS_8      = 4'h8;
	localparam logic [3:0] HOURS_12     = 4'hc;
	localparam logic [3:0] PRECHG_HOURS = 4'h2;
	localparam longint HOUR_S           = 3600;
	localparam longint CLK_PERIOD_NS    = 10;
	localparam logic [38:0] HOUR_CYCLES = 39'(HOUR_S * 64'd1000000000 / CLK_PERIOD_NS);

endpackage : cctl_pkg

// file: logic/cctl_hour_tick.sv
// hour prescaler shared by the charge safety timers
`timescale 1ns/1ps
`default_nettype none

module cctl_hour_tick #(
	parameter logic [38:0] HOUR_CYCLES = cctl_pkg::HOUR_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// control
	input  wire logic restart,
	input  wire logic slowReq,
	// tick out
	output logic      hourPulse
);

	typedef struct packed {
		logic [38:0] count;
		logic        halfPhase;
		logic        pulse;
	} cctl_tick_t;

	cctl_tick_t state_q;
	cctl_tick_t state_d;

	// when slowed, advance only every other cycle, so the hour takes twice as long
	always_comb begin
		state_d       = state_q;
		state_d.pulse = 1'b0;
		if (restart) begin
			state_d.count     = '0;
			state_d.halfPhase = 1'b0;
		end else begin
			state_d.halfPhase = ~state_q.halfPhase;
			if (!slowReq || state_q.halfPhase) begin
				if (state_q.count == HOUR_CYCLES - 39'd1) begin
					state_d.count = '0;
					state_d.pulse = 1'b1;
				end else begin
					state_d.count = state_q.count + 39'd1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign hourPulse = state_q.pulse;

	a_slow_holds: assert property (@(posedge mclk) disable iff (!resetn)
		(slowReq && !state_q.halfPhase && !restart) |=> (state_q.count == $past(state_q.count)))
		else $error("slowed prescaler advanced on a skip cycle");

endmodule : cctl_hour_tick

`default_nettype wire

// file: logic/cctl_hour_timer.sv
// one charge safety timer counting whole hours up to a limit
`timescale 1ns/1ps
`default_nettype none

module cctl_hour_timer (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// control
	input  wire logic       run,
	input  wire logic       clear,
	input  wire logic       hourPulse,
	input  wire logic [3:0] limit,
	// status
	output logic            expired
);

	typedef struct packed {
		logic [3:0] count;
		logic       expired;
	} cctl_htmr_t;

	cctl_htmr_t state_q;
	cctl_htmr_t state_d;

	// a stopped timer forgets its elapsed time and any timeout
	always_comb begin
		state_d = state_q;
		if (clear || !run) begin
			state_d = '0;
		end else if (hourPulse && !state_q.expired) begin
			state_d.count = state_q.count + 4'h1;
			if (state_q.count + 4'h1 >= limit) begin
				state_d.expired = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign expired = state_q.expired;

	a_stop_no_expiry: assert property (@(posedge mclk) disable iff (!resetn)
		!run |=> !state_q.expired)
		else $error("stopped timer reports a timeout");

	a_expiry_at_limit: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(state_q.expired) |-> (state_q.count == $past(limit)))
		else $error("timer expired at the wrong hour count");

endmodule : cctl_hour_timer

`default_nettype wire

// file: logic/cctl_charger_regs.sv
// charger timer control and control-zero register bank with safety timers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module cctl_charger_regs #(
	parameter logic [38:0] HOUR_CYCLES = cctl_pkg::HOUR_CYCLES
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStrobe,
	input  wire logic       rdStrobe,
	output logic      [7:0] rdData,
	// events and status from the power stage
	input  wire logic       wdExpired,
	input  wire logic       adapterPlugged,
	input  wire logic       optimizerStarted,
	input  wire logic       overVoltageFault,
	input  wire logic       inputPowerMgmt,
	input  wire logic       thermalReg,
	input  wire logic       prechargePhase,
	input  wire logic       fastChargePhase,
	// configuration out to the power stage
	output logic            chargeEnable,
	output logic            termEnable,
	output logic            hizEnable,
	output logic            optimizerEnable,
	output logic            optimizerStart,
	output logic            dischargeEnable,
	// safety timer status
	output logic            prechargeTimeout,
	output logic            fastChargeTimeout
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] timerReg;
		logic [7:0] ctrlReg;
		logic [7:0] rdData;
		logic       discharge;
	} cctl_regs_t;

	cctl_regs_t state_q;
	cctl_regs_t state_d;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	logic wrTimer;
	logic wrCtrl;
	logic regResetWr;
	logic startTake;
	logic slowReq;
	logic preRun;
	logic fastRun;
	logic preClear;
	logic fastClear;
	logic hourPulse;
	logic [3:0] fastLimit;
	logic preExpired;
	logic fastExpired;

	// strobes per register
	assign wrTimer    = wrStrobe && (addr == cctl_pkg::TIMER_CTRL_ADDR);
	assign wrCtrl     = wrStrobe && (addr == cctl_pkg::CHG_CTRL0_ADDR);
	assign regResetWr = wrStrobe && (addr == cctl_pkg::REG_RESET_ADDR)
		&& wrData[cctl_pkg::BIT_REG_RESET];

	// a start request only counts while the optimizer is already enabled
	assign startTake = wrCtrl && wrData[cctl_pkg::BIT_OPT_START]
		&& state_q.ctrlReg[cctl_pkg::BIT_OPT_EN];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// order of the updates sets priority: watchdog, then hardware events,
	// then the software write, and register reset above everything
	always_comb begin
		state_d        = state_q;
		state_d.rdData = 8'h00;

		// watchdog restores only its own class of fields
		if (wdExpired) begin
			state_d.timerReg = cctl_pkg::TIMER_CTRL_RESET;
			state_d.ctrlReg  = (state_q.ctrlReg & ~cctl_pkg::CHG_CTRL0_WD_MASK)
				| (cctl_pkg::CHG_CTRL0_RESET & cctl_pkg::CHG_CTRL0_WD_MASK);
		end

		// optimizer has begun, the one-shot drops
		if (optimizerStarted) begin
			state_d.ctrlReg[cctl_pkg::BIT_OPT_START] = 1'b0;
		end

		// a newly plugged adapter leaves high-impedance mode
		if (adapterPlugged) begin
			state_d.ctrlReg[cctl_pkg::BIT_HIZ] = 1'b0;
		end

		// timer control is fully read-write
		if (wrTimer) begin
			state_d.timerReg = wrData;
		end

		// control zero: start bit can be set but never cleared by software
		if (wrCtrl) begin
			state_d.ctrlReg = (wrData & cctl_pkg::CHG_CTRL0_RW_MASK)
				| (state_d.ctrlReg & ~cctl_pkg::CHG_CTRL0_RW_MASK);
			// the raw written bit must not land: a refused start keeps the earlier state
			state_d.ctrlReg[cctl_pkg::BIT_OPT_START] = startTake
				|| (state_q.ctrlReg[cctl_pkg::BIT_OPT_START] && !optimizerStarted && !wdExpired);
		end

		// register reset returns every field to its default
		if (regResetWr) begin
			state_d.timerReg = cctl_pkg::TIMER_CTRL_RESET;
			state_d.ctrlReg  = cctl_pkg::CHG_CTRL0_RESET;
		end

		// discharge follows the registered fields and the fault level
		state_d.discharge = state_q.ctrlReg[cctl_pkg::BIT_FORCE_DIS]
			|| (state_q.ctrlReg[cctl_pkg::BIT_AUTO_DIS] && overVoltageFault);

		// read data valid in the cycle after the strobe only
		if (rdStrobe) begin
			unique case (addr)
				cctl_pkg::TIMER_CTRL_ADDR: state_d.rdData = state_q.timerReg;
				cctl_pkg::CHG_CTRL0_ADDR:  state_d.rdData = state_q.ctrlReg & cctl_pkg::CHG_CTRL0_RW_MASK;
				default:                   state_d.rdData = 8'h00; // unmapped and reset trigger read zero
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// reset values come from the package, matching the register defaults
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q.timerReg  <= cctl_pkg::TIMER_CTRL_RESET;
			state_q.ctrlReg   <= cctl_pkg::CHG_CTRL0_RESET;
			state_q.rdData    <= 8'h00;
			state_q.discharge <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// safety timers
	// ------------------------------------------------------------
	// slowdown only applies while the input or thermal loop is limiting
	assign slowReq = state_q.timerReg[cctl_pkg::BIT_SLOWDOWN]
		&& (inputPowerMgmt || thermalReg);

	// timers run only in their phase, with charging and the timer enabled
	assign preRun  = prechargePhase && state_q.ctrlReg[cctl_pkg::BIT_CHG_EN]
		&& state_q.timerReg[cctl_pkg::BIT_PRECHG_EN];
	assign fastRun = fastChargePhase && state_q.ctrlReg[cctl_pkg::BIT_CHG_EN]
		&& state_q.timerReg[cctl_pkg::BIT_FAST_EN];

	// register reset restarts the timers as well as the fields
	assign preClear  = regResetWr;
	assign fastClear = regResetWr;

	// duration decode; the unused code falls back to the longest duration
	always_comb begin
		unique case (state_q.timerReg[cctl_pkg::BIT_DUR_MSB:cctl_pkg::BIT_DUR_LSB])
			cctl_pkg::DUR_CODE_5H:  fastLimit = cctl_pkg::HOURS_5;
			cctl_pkg::DUR_CODE_8H:  fastLimit = cctl_pkg::HOURS_8;
			cctl_pkg::DUR_CODE_12H: fastLimit = cctl_pkg::HOURS_12;
			default:                fastLimit = cctl_pkg::HOURS_12;
		endcase
	end

	// shared hour prescaler
	cctl_hour_tick #(
		.HOUR_CYCLES (HOUR_CYCLES)
	) u_tick (
		.mclk      (mclk),
		.resetn    (resetn),
		.restart   (regResetWr),
		.slowReq   (slowReq),
		.hourPulse (hourPulse)
	);

	// pre-charge timer
	cctl_hour_timer u_preTimer (
		.mclk      (mclk),
		.resetn    (resetn),
		.run       (preRun),
		.clear     (preClear),
		.hourPulse (hourPulse),
		.limit     (cctl_pkg::PRECHG_HOURS),
		.expired   (preExpired)
	);

	// fast-charge timer
	cctl_hour_timer u_fastTimer (
		.mclk      (mclk),
		.resetn    (resetn),
		.run       (fastRun),
		.clear     (fastClear),
		.hourPulse (hourPulse),
		.limit     (fastLimit),
		.expired   (fastExpired)
	);

	// ------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------
	assign rdData            = state_q.rdData;
	assign chargeEnable      = state_q.ctrlReg[cctl_pkg::BIT_CHG_EN];
	assign termEnable        = state_q.ctrlReg[cctl_pkg::BIT_TERM];
	assign hizEnable         = state_q.ctrlReg[cctl_pkg::BIT_HIZ];
	assign optimizerEnable   = state_q.ctrlReg[cctl_pkg::BIT_OPT_EN];
	assign optimizerStart    = state_q.ctrlReg[cctl_pkg::BIT_OPT_START];
	assign dischargeEnable   = state_q.discharge;
	assign prechargeTimeout  = preExpired;
	assign fastChargeTimeout = fastExpired;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_ctrlRead;
		rdStrobe && (addr == cctl_pkg::CHG_CTRL0_ADDR);
	endsequence

	sequence s_plainCtrlWrite;
		wrCtrl && !wdExpired && !regResetWr;
	endsequence

	a_reg_reset_defaults: assert property (
		regResetWr |=> (state_q.ctrlReg == cctl_pkg::CHG_CTRL0_RESET)
			&& (state_q.timerReg == cctl_pkg::TIMER_CTRL_RESET))
		else $error("register reset did not restore defaults");

	a_ctrl_read_back: assert property (
		s_ctrlRead |=> (rdData == $past(state_q.ctrlReg)) && !rdData[0])
		else $error("control read returned wrong data");

	a_watchdog_keeps: assert property (
		(wdExpired && !wrStrobe && !adapterPlugged) |=> (state_q.timerReg == cctl_pkg::TIMER_CTRL_RESET)
			&& (hizEnable == $past(hizEnable)) && (optimizerEnable == $past(optimizerEnable))
			&& chargeEnable && termEnable)
		else $error("watchdog restored the wrong field set");

	a_start_needs_enable: assert property (
		(s_plainCtrlWrite and (wrData[cctl_pkg::BIT_OPT_START] && !optimizerEnable
			&& !optimizerStart)) |=> !optimizerStart)
		else $error("optimizer start accepted while disabled");

	a_start_self_clear: assert property (
		(optimizerStarted && !wrStrobe) |=> !optimizerStart)
		else $error("optimizer start did not clear");

	a_plug_clears_hiz: assert property (
		(adapterPlugged && !wrCtrl) |=> !hizEnable)
		else $error("adapter plug left high-impedance set");

	a_term_written: assert property (
		s_plainCtrlWrite |=> (termEnable == $past(wrData[cctl_pkg::BIT_TERM])))
		else $error("termination enable not written");

	a_forced_discharge: assert property (
		state_q.ctrlReg[cctl_pkg::BIT_FORCE_DIS] |=> dischargeEnable)
		else $error("forced discharge not applied");

	a_auto_discharge: assert property (
		!state_q.ctrlReg[cctl_pkg::BIT_FORCE_DIS] |=>
			(dischargeEnable == ($past(state_q.ctrlReg[cctl_pkg::BIT_AUTO_DIS]) && $past(overVoltageFault))))
		else $error("auto discharge does not follow the fault");

	a_fast_disabled: assert property (
		!state_q.timerReg[cctl_pkg::BIT_FAST_EN] ##1 !state_q.timerReg[cctl_pkg::BIT_FAST_EN]
			|-> !fastChargeTimeout)
		else $error("disabled fast-charge timer timed out");

	a_charge_off_stops: assert property (
		!chargeEnable ##1 !chargeEnable |-> !prechargeTimeout && !fastChargeTimeout)
		else $error("timers ran while charging disabled");

	// ------------------------------------------------------------
	// field, timer and read checks
	// ------------------------------------------------------------
	a_timer_written: assert property (
		wrTimer |=> (state_q.timerReg == $past(wrData)))
		else $error("timer control write lost");

	a_pre_disabled: assert property (
		!state_q.timerReg[cctl_pkg::BIT_PRECHG_EN] ##1 !state_q.timerReg[cctl_pkg::BIT_PRECHG_EN]
			|-> !prechargeTimeout)
		else $error("disabled pre-charge timer timed out");

	a_dur_five: assert property (
		(state_q.timerReg[cctl_pkg::BIT_DUR_MSB:cctl_pkg::BIT_DUR_LSB] == cctl_pkg::DUR_CODE_5H)
			|-> (fastLimit == cctl_pkg::HOURS_5))
		else $error("duration code zero is not five hours");

	a_dur_eight: assert property (
		(state_q.timerReg[cctl_pkg::BIT_DUR_MSB:cctl_pkg::BIT_DUR_LSB] == cctl_pkg::DUR_CODE_8H)
			|-> (fastLimit == cctl_pkg::HOURS_8))
		else $error("duration code one is not eight hours");

	a_dur_twelve: assert property (
		(state_q.timerReg[cctl_pkg::BIT_DUR_MSB:cctl_pkg::BIT_DUR_LSB] == cctl_pkg::DUR_CODE_12H)
			|-> (fastLimit == cctl_pkg::HOURS_12))
		else $error("duration code two is not twelve hours");

	a_slow_off: assert property (
		!state_q.timerReg[cctl_pkg::BIT_SLOWDOWN] |-> !slowReq)
		else $error("timers slowed with slowdown off");

	a_charge_written: assert property (
		s_plainCtrlWrite |=> (chargeEnable == $past(wrData[cctl_pkg::BIT_CHG_EN])))
		else $error("charge enable not written");

	a_opt_written: assert property (
		s_plainCtrlWrite |=> (optimizerEnable == $past(wrData[cctl_pkg::BIT_OPT_EN])))
		else $error("optimizer enable not written");

	a_hiz_written: assert property (
		s_plainCtrlWrite |=> (hizEnable == $past(wrData[cctl_pkg::BIT_HIZ])))
		else $error("high-impedance enable not written");

	a_start_accepted: assert property (
		(wrCtrl && wrData[cctl_pkg::BIT_OPT_START] && optimizerEnable) |=> optimizerStart)
		else $error("optimizer start refused while enabled");

	a_watchdog_spares: assert property (
		(wdExpired && !wrStrobe) |=>
			(state_q.ctrlReg[cctl_pkg::BIT_AUTO_DIS] == $past(state_q.ctrlReg[cctl_pkg::BIT_AUTO_DIS]))
			&& (state_q.ctrlReg[cctl_pkg::BIT_FORCE_DIS] == $past(state_q.ctrlReg[cctl_pkg::BIT_FORCE_DIS])))
		else $error("watchdog touched the discharge fields");

	a_reset_stops_timers: assert property (
		regResetWr |=> !prechargeTimeout && !fastChargeTimeout)
		else $error("register reset left a timer expired");

	a_read_idle_zero: assert property (
		!rdStrobe |=> (rdData == 8'h00))
		else $error("read data stood without a read strobe");

endmodule : cctl_charger_regs

`default_nettype wire

// file: sim/cctl_charger_regs_bench.sv
// self-checking bench for the charger timer and control register bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin testsRun++; if ((got) !== (exp)) begin mismatches++; $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module cctl_charger_regs_bench;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [38:0] HC = 39'h14; // twenty-cycle hour keeps the run short
	localparam int          H  = 20;
	logic       mclk;
	logic       resetn;
	logic [7:0] addr;
	logic [7:0] wrData;
	logic       wrStrobe;
	logic       rdStrobe;
	logic [7:0] rdData;
	logic       wdExpired;
	logic       adapterPlugged;
	logic       optimizerStarted;
	logic       overVoltageFault;
	logic       inputPowerMgmt;
	logic       thermalReg;
	logic       prechargePhase;
	logic       fastChargePhase;
	logic       chargeEnable;
	logic       termEnable;
	logic       hizEnable;
	logic       optimizerEnable;
	logic       optimizerStart;
	logic       dischargeEnable;
	logic       prechargeTimeout;
	logic       fastChargeTimeout;
	int         mismatches;
	int         testsRun;

	cctl_charger_regs #(.HOUR_CYCLES(HC)) cctl_charger_regs_i (
		.mclk(mclk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .wdExpired(wdExpired), .adapterPlugged(adapterPlugged),
		.optimizerStarted(optimizerStarted), .overVoltageFault(overVoltageFault),
		.inputPowerMgmt(inputPowerMgmt), .thermalReg(thermalReg), .prechargePhase(prechargePhase),
		.fastChargePhase(fastChargePhase), .chargeEnable(chargeEnable), .termEnable(termEnable),
		.hizEnable(hizEnable), .optimizerEnable(optimizerEnable), .optimizerStart(optimizerStart),
		.dischargeEnable(dischargeEnable), .prechargeTimeout(prechargeTimeout),
		.fastChargeTimeout(fastChargeTimeout)
	);

	// free-running clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// bus and event helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'b1;
		@(posedge mclk);
		wrStrobe <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr     <= a;
		rdStrobe <= 1'b1;
		@(posedge mclk);
		rdStrobe <= 1'b0;
		#1;
		d = rdData;
	endtask : rd

	task automatic chkReg(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rd(a, d);
		`CHK(what, exp, d)
	endtask : chkReg

	// one-cycle pulse on {watchdog, adapter, optimizer started}
	task automatic evt(input logic [2:0] sel);
		@(posedge mclk);
		{wdExpired, adapterPlugged, optimizerStarted} <= sel;
		@(posedge mclk);
		{wdExpired, adapterPlugged, optimizerStarted} <= 3'h0;
		#1;
	endtask : evt

	task automatic regReset();
		wr(8'h09, 8'h40);
	endtask : regReset

	// discharge output lags its inputs by one cycle
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle

	task automatic conclude();
		$display("checks %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testReset();
		chkReg(8'h0e, 8'h3d, "timer reg reset");
		chkReg(8'h0f, 8'ha2, "control reg reset");
		`CHK("chargeEnable", 1'b1, chargeEnable)
		`CHK("optimizerEnable", 1'b0, optimizerEnable)
		chkReg(8'h33, 8'h00, "unmapped read");
		$display("test reset done");
	endtask : testReset

	task automatic testControl();
		wr(8'h0f, 8'h82);
		`CHK("charge off", 1'b0, chargeEnable)
		wr(8'h0f, 8'ha1);
		`CHK("term off", 1'b0, termEnable)
		chkReg(8'h0f, 8'ha0, "reserved bit");
		wr(8'h0f, 8'haa);
		chkReg(8'h0f, 8'ha2, "start while disabled");
		wr(8'h0f, 8'hb2);
		`CHK("optimizer on", 1'b1, optimizerEnable)
		wr(8'h0f, 8'hba);
		`CHK("start set", 1'b1, optimizerStart)
		wr(8'h0f, 8'hb2);
		chkReg(8'h0f, 8'hba, "start set only");
		evt(3'h1);
		chkReg(8'h0f, 8'hb2, "start self clear");
		wr(8'h0f, 8'ha6);
		`CHK("hiz on", 1'b1, hizEnable)
		evt(3'h2);
		`CHK("hiz plug clear", 1'b0, hizEnable)
		regReset();
		$display("test control done");
	endtask : testControl

	task automatic testDischarge();
		@(posedge mclk);
		overVoltageFault <= 1'b1;
		settle();
		`CHK("auto discharge", 1'b1, dischargeEnable)
		wr(8'h0f, 8'h22);
		settle();
		`CHK("auto off", 1'b0, dischargeEnable)
		wr(8'h0f, 8'h62);
		overVoltageFault <= 1'b0;
		settle();
		`CHK("forced discharge", 1'b1, dischargeEnable)
		regReset();
		$display("test discharge done");
	endtask : testDischarge

	task automatic testRestore();
		wr(8'h0e, 8'h00);
		wr(8'h0f, 8'h50);
		wr(8'h0f, 8'h5c);
		evt(3'h4);
		chkReg(8'h0e, 8'h3d, "wd timer reg");
		chkReg(8'h0f, 8'h76, "wd control reg");
		wr(8'h33, 8'h00);
		regReset();
		chkReg(8'h0f, 8'ha2, "reg reset control");
		chkReg(8'h09, 8'h00, "reset trigger reads");
		$display("test restore done");
	endtask : testRestore

	// cycles until the chosen timer expires, 1000 when it never does
	task automatic measure(input logic pre, output int n);
		n = 0;
		@(posedge mclk);
		prechargePhase  <= pre;
		fastChargePhase <= !pre;
		while (n < 1000 && (pre ? prechargeTimeout : fastChargeTimeout) !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		prechargePhase  <= 1'b0;
		fastChargePhase <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : measure

	function automatic logic inRange(input int n, input int hrs, input int f);
		return (n > (hrs - 1) * H * f) && (n <= hrs * H * f + 4);
	endfunction : inRange

	task automatic testTimers();
		logic [7:0] cfg [0:5] = '{8'h19, 8'h1b, 8'h1d, 8'h19, 8'h18, 8'h19};
		int         hrs [0:5] = '{5, 8, 12, 5, 5, 2};
		int         fac [0:5] = '{1, 1, 1, 2, 1, 1};
		int         n;
		for (int i = 0; i < 6; i++) begin
			wr(8'h0e, cfg[i]);
			inputPowerMgmt <= (i == 3);
			thermalReg     <= (i == 4);
			measure(i == 5, n);
			if (n >= 1000) begin
				mismatches++;
				conclude();
			end
			`CHK("timer length", 1'b1, inRange(n, hrs[i], fac[i]))
		end
		inputPowerMgmt <= 1'b0;
		thermalReg     <= 1'b0;
		wr(8'h0e, 8'h11);
		measure(1'b0, n);
		`CHK("fast timer off", 1'b1, n >= 1000)
		wr(8'h0e, 8'h09);
		measure(1'b1, n);
		`CHK("pre timer off", 1'b1, n >= 1000)
		$display("test timers done");
	endtask : testTimers

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches       = 0;
		testsRun         = 0;
		resetn           = 1'b0;
		addr             = 8'h00;
		wrData           = 8'h00;
		wrStrobe         = 1'b0;
		rdStrobe         = 1'b0;
		wdExpired        = 1'b0;
		adapterPlugged   = 1'b0;
		optimizerStarted = 1'b0;
		overVoltageFault = 1'b0;
		inputPowerMgmt   = 1'b0;
		thermalReg       = 1'b0;
		prechargePhase   = 1'b0;
		fastChargePhase  = 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		testReset();
		testControl();
		testDischarge();
		testRestore();
		testTimers();
		conclude();
	end

endmodule : cctl_charger_regs_bench

`default_nettype wire
